// *** gpio_dbnc.sv ***
// debounce filter for one synchronised pin
`timescale 1ns/10ps
`include "gpio_defines.svh"

module gpio_dbnc #(
   parameter int TICKS = `GPIO_DB_TICKS,
   parameter int CW = `GPIO_DB_CW
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic en,
   input wire logic d,
   output logic q
);

   generate
      if (TICKS < 1 || TICKS >= (1 << CW)) begin : g_bad
         $error("gpio_dbnc: TICKS does not fit CW");
      end
   endgenerate

   localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

   logic [CW-1:0] cnt_q;
   logic q_q;

   // ******************************
   // stability counter
   // ******************************
   // glitch filter count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (!en || d == q_q) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= 1'b0;
      end else if (!en) begin
         q_q <= d;
      end else if (tick && d != q_q && cnt_q == LAST) begin
         q_q <= d;
      end
   end

   assign q = q_q;

   // ******************************
   // checks
   // ******************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   glitch_block_a: assert property ((en && !tick) |=> $stable(q_q))
      else $error("filtered level moved without a tick");

endmodule

// *** gpio_defines.svh ***
// constants of the general-purpose io port: offsets, reset values, counts
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ******************************
// register offsets
// ******************************
`define GPIO_OFS_DOUT     8'h00
`define GPIO_OFS_DIN      8'h04
`define GPIO_OFS_DIR      8'h08
`define GPIO_OFS_SET      8'h0c
`define GPIO_OFS_CLR      8'h10
`define GPIO_OFS_INTEN    8'h14
`define GPIO_OFS_INTMASK  8'h18
`define GPIO_OFS_INTSTAT  8'h1c
`define GPIO_OFS_INTMSTAT 8'h20
`define GPIO_OFS_LEVEL    8'h24
`define GPIO_OFS_BOTH     8'h28
`define GPIO_OFS_POL      8'h2c
`define GPIO_OFS_PULLEN   8'h30
`define GPIO_OFS_PULLUP   8'h34
`define GPIO_OFS_DBEN     8'h38
`define GPIO_OFS_DBPRE    8'h3c

// ******************************
// reset values and counts
// ******************************
`define GPIO_RST_ZERO     32'h0000_0000
`define GPIO_RST_DBPRE    16'h00ff
`define GPIO_DB_TICKS     4
`define GPIO_DB_CW        4

`endif

// *** gpio_pads.sv ***
// board-side model of the general-purpose pins: external drivers, pulls, floating lines
`timescale 1ns/10ps

module gpio_pads #(
   parameter int N = 8
) (
   input wire logic pclk,
   input wire logic [N-1:0] pad_drive,
   input wire logic [N-1:0] pad_oe_n,
   input wire logic [N-1:0] pad_pull_en,
   input wire logic [N-1:0] pad_pull_up,
   input wire logic [N-1:0] ext_en,
   input wire logic [N-1:0] ext_val,
   output logic [N-1:0] pad_level
);
   // a line nobody drives or pulls changes every cycle
   logic [N-1:0] float_q = '0;

   always @(posedge pclk) begin
      float_q <= ~float_q;
   end

   assign pad_level = (~pad_oe_n & pad_drive) | (pad_oe_n & ext_en & ext_val)
      | (pad_oe_n & ~ext_en & pad_pull_en & pad_pull_up)
      | (pad_oe_n & ~ext_en & ~pad_pull_en & float_q);
endmodule

// *** gpio_pkg.sv ***
// types of the general-purpose io port
package gpio_pkg;

   // sense code is {level, both, polarity}
   typedef enum logic [2:0] {
      GPIO_SENSE_RISE = 3'b000,
      GPIO_SENSE_FALL = 3'b001,
      GPIO_SENSE_BOTH = 3'b010,
      GPIO_SENSE_BOTH_ALT = 3'b011,
      GPIO_SENSE_HIGH = 3'b100,
      GPIO_SENSE_LOW = 3'b101
   } gpio_sense_t;

endpackage

// *** gpio_port.sv ***
// general-purpose io port with apb registers, sense logic and debounce
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "gpio_defines.svh"

module gpio_port #(
   parameter int N = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N-1:0] pad_level,
   output logic [N-1:0] pad_drive,
   output logic [N-1:0] pad_oe_n,
   output logic [N-1:0] pad_pull_en,
   output logic [N-1:0] pad_pull_up,
   output logic irq
);

   generate
      if (N < 1 || N > 32) begin : g_bad
         $error("gpio_port: N must lie in 1..32");
      end
   endgenerate

   localparam logic [N-1:0] RST_N = N'(`GPIO_RST_ZERO);

   // ******************************
   // declarations
   // ******************************
   logic [N-1:0] dout_q;
   logic [N-1:0] dir_q;
   logic [N-1:0] inten_q;
   logic [N-1:0] mask_q;
   logic [N-1:0] stat_q;
   logic [N-1:0] stat_d;
   logic [N-1:0] level_q;
   logic [N-1:0] both_q;
   logic [N-1:0] pol_q;
   logic [N-1:0] pullen_q;
   logic [N-1:0] pullup_q;
   logic [N-1:0] dben_q;
   logic [15:0] dbpre_q;
   logic [15:0] pre_cnt_q;
   logic db_tick;
   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   logic [N-1:0] filt;
   logic [N-1:0] prev_q;
   logic [N-1:0] edge_hit;
   logic [N-1:0] lvl_hit;
   logic [N-1:0] is_lvl;
   logic [N-1:0] w1c;
   logic [N-1:0] keep_v;
   logic [N-1:0] wdat;
   logic [31:0] rdata_d;
   logic map_ok;
   logic wr_acc;
   logic setup_ph;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic irq_q;
   logic [N-1:0] drive_q;
   logic [N-1:0] oe_n_q;
   logic [N-1:0] pull_en_q;
   logic [N-1:0] pull_up_q;

   // ******************************
   // apb slave
   // ******************************
   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pready_q && pwrite;
   assign wdat = pwdata[N-1:0];

   always_comb begin
      rdata_d = 32'h0000_0000;
      map_ok = 1'b1;
      case (paddr)
         `GPIO_OFS_DOUT: rdata_d[N-1:0] = dout_q;
         `GPIO_OFS_DIN: rdata_d[N-1:0] = filt;
         `GPIO_OFS_DIR: rdata_d[N-1:0] = dir_q;
         `GPIO_OFS_SET: rdata_d = 32'h0000_0000;
         `GPIO_OFS_CLR: rdata_d = 32'h0000_0000;
         `GPIO_OFS_INTEN: rdata_d[N-1:0] = inten_q;
         `GPIO_OFS_INTMASK: rdata_d[N-1:0] = mask_q;
         `GPIO_OFS_INTSTAT: rdata_d[N-1:0] = stat_q;
         `GPIO_OFS_INTMSTAT: rdata_d[N-1:0] = stat_q & mask_q;
         `GPIO_OFS_LEVEL: rdata_d[N-1:0] = level_q;
         `GPIO_OFS_BOTH: rdata_d[N-1:0] = both_q;
         `GPIO_OFS_POL: rdata_d[N-1:0] = pol_q;
         `GPIO_OFS_PULLEN: rdata_d[N-1:0] = pullen_q;
         `GPIO_OFS_PULLUP: rdata_d[N-1:0] = pullup_q;
         `GPIO_OFS_DBEN: rdata_d[N-1:0] = dben_q;
         `GPIO_OFS_DBPRE: rdata_d[15:0] = dbpre_q;
         default: map_ok = 1'b0;
      endcase
   end

   // answer is prepared in the setup cycle; access always lasts one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_ph;
         if (setup_ph) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= !map_ok;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ******************************
   // output data and direction
   // ******************************
   // bitwise set and clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= RST_N;
      end else if (wr_acc && paddr == `GPIO_OFS_DOUT) begin
         dout_q <= wdat;
      end else if (wr_acc && paddr == `GPIO_OFS_SET) begin
         dout_q <= dout_q | wdat;
      end else if (wr_acc && paddr == `GPIO_OFS_CLR) begin
         dout_q <= dout_q & ~wdat;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= RST_N;
      end else if (wr_acc && paddr == `GPIO_OFS_DIR) begin
         dir_q <= wdat;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_q <= RST_N;
         oe_n_q <= ~RST_N;
      end else begin
         drive_q <= dout_q;
         oe_n_q <= ~dir_q;
      end
   end

   assign pad_drive = drive_q;
   assign pad_oe_n = oe_n_q;

   // ******************************
   // configuration registers
   // ******************************
   // interrupt input select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inten_q <= RST_N;
         mask_q <= RST_N;
      end else if (wr_acc && paddr == `GPIO_OFS_INTEN) begin
         inten_q <= wdat;
      end else if (wr_acc && paddr == `GPIO_OFS_INTMASK) begin
         mask_q <= wdat;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= RST_N;
         both_q <= RST_N;
         pol_q <= RST_N;
      end else if (wr_acc) begin
         if (paddr == `GPIO_OFS_LEVEL) begin
            level_q <= wdat;
         end
         if (paddr == `GPIO_OFS_BOTH) begin
            both_q <= wdat;
         end
         if (paddr == `GPIO_OFS_POL) begin
            pol_q <= wdat;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullen_q <= RST_N;
         pullup_q <= RST_N;
      end else if (wr_acc && paddr == `GPIO_OFS_PULLEN) begin
         pullen_q <= wdat;
      end else if (wr_acc && paddr == `GPIO_OFS_PULLUP) begin
         pullup_q <= wdat;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pull_en_q <= RST_N;
         pull_up_q <= RST_N;
      end else begin
         pull_en_q <= pullen_q;
         pull_up_q <= pullup_q;
      end
   end

   assign pad_pull_en = pull_en_q;
   assign pad_pull_up = pull_up_q;

   // ******************************
   // input path and debounce
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= RST_N;
         sync2_q <= RST_N;
      end else begin
         sync1_q <= pad_level;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dben_q <= RST_N;
         dbpre_q <= `GPIO_RST_DBPRE;
      end else if (wr_acc && paddr == `GPIO_OFS_DBEN) begin
         dben_q <= wdat;
      end else if (wr_acc && paddr == `GPIO_OFS_DBPRE) begin
         dbpre_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_q <= 16'h0000;
      end else if (pre_cnt_q >= dbpre_q) begin
         pre_cnt_q <= 16'h0000;
      end else begin
         pre_cnt_q <= pre_cnt_q + 16'h0001;
      end
   end

   assign db_tick = (pre_cnt_q >= dbpre_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= RST_N;
      end else begin
         prev_q <= filt;
      end
   end

   // ******************************
   // per-pin filter and sense
   // ******************************
   generate
      for (genvar i = 0; i < N; i++) begin : g_pin
         gpio_pkg::gpio_sense_t sense;
         logic rise;
         logic fall;

         gpio_dbnc u_dbnc (
            .pclk(pclk),
            .presetn(presetn),
            .tick(db_tick),
            .en(dben_q[i]),
            .d(sync2_q[i]),
            .q(filt[i])
         );

         assign rise = filt[i] && !prev_q[i];
         assign fall = !filt[i] && prev_q[i];

         always_comb begin
            sense = gpio_pkg::gpio_sense_t'({level_q[i], both_q[i], pol_q[i]});
            edge_hit[i] = 1'b0;
            lvl_hit[i] = 1'b0;
            is_lvl[i] = 1'b0;
            case (sense)
               gpio_pkg::GPIO_SENSE_RISE: edge_hit[i] = rise;
               gpio_pkg::GPIO_SENSE_FALL: edge_hit[i] = fall;
               gpio_pkg::GPIO_SENSE_BOTH: edge_hit[i] = rise || fall;
               gpio_pkg::GPIO_SENSE_BOTH_ALT: edge_hit[i] = rise || fall;
               gpio_pkg::GPIO_SENSE_HIGH: begin
                  is_lvl[i] = 1'b1;
                  lvl_hit[i] = filt[i];
               end
               gpio_pkg::GPIO_SENSE_LOW: begin
                  is_lvl[i] = 1'b1;
                  lvl_hit[i] = !filt[i];
               end
               default: begin
                  is_lvl[i] = 1'b1;
                  lvl_hit[i] = pol_q[i] ? !filt[i] : filt[i];
               end
            endcase
            edge_hit[i] = edge_hit[i] && inten_q[i];
            lvl_hit[i] = lvl_hit[i] && inten_q[i];
         end
      end
   endgenerate

   // ******************************
   // interrupt status and request
   // ******************************
   assign w1c = (wr_acc && paddr == `GPIO_OFS_INTSTAT) ? wdat : RST_N;
   assign keep_v = stat_q & ~w1c & ~is_lvl;

   always_comb begin
      stat_d = keep_v | edge_hit | lvl_hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= RST_N;
      end else begin
         stat_q <= stat_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign irq = irq_q;

   // ******************************
   // checks
   // ******************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable;
   endsequence

   sequence access_s;
      psel && penable && pready;
   endsequence

   apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
      else $error("apb access did not end after one cycle");

   dir_hold_a: assert property (!(wr_acc && paddr == `GPIO_OFS_DIR) |=> $stable(dir_q))
      else $error("direction changed without a write");

   pad_enable_a: assert property (##1 pad_oe_n == ~$past(dir_q))
      else $error("pad enable does not follow direction");

   set_bits_a: assert property (setup_s ##1 (access_s and (pwrite && paddr == `GPIO_OFS_SET))
      |=> dout_q == ($past(dout_q) | $past(wdat)))
      else $error("set write disturbed other bits");

   clr_bits_a: assert property (setup_s ##1 (access_s and (pwrite && paddr == `GPIO_OFS_CLR))
      |=> dout_q == ($past(dout_q) & ~$past(wdat)))
      else $error("clear write disturbed other bits");

   edge_latch_a: assert property (1 |=> (stat_q & $past(keep_v)) == $past(keep_v))
      else $error("edge status lost before clear");

   edge_set_a: assert property (1 |=> (stat_q & $past(edge_hit)) == $past(edge_hit))
      else $error("detected edge did not set status");

   level_follow_a: assert property (1 |=> (stat_q & $past(is_lvl)) == $past(lvl_hit))
      else $error("level status does not follow input");

   irq_gate_a: assert property (##1 irq == $past(|(stat_q & mask_q)))
      else $error("request line does not match masked status");

   pull_sel_a: assert property (##1 pad_pull_up == $past(pullup_q)
      && pad_pull_en == $past(pullen_q))
      else $error("pull select not passed to pad");

endmodule

// *** test_general_purpose_io_port.sv ***
// self-checking bench of the general-purpose io port over apb
`timescale 1ns/10ps
`include "gpio_defines.svh"

module test_general_purpose_io_port;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_q;
   logic [7:0] paddr, pad_level, pad_drive, pad_oe_n, pad_pull_en, pad_pull_up;
   logic [7:0] ext_en, ext_val, d, s, c, p, mk, e;
   logic [31:0] pwdata, prdata, rd_q;
   logic [2:0] md;
   gpio_pkg::gpio_sense_t modes [6];
   int bad_count, tests_run;

   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end

   gpio_port #(.N(8)) gpio_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_level(pad_level), .pad_drive(pad_drive),
      .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up), .irq(irq));

   gpio_pads #(.N(8)) gpio_pads_inst (.pclk(pclk), .pad_drive(pad_drive),
      .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up),
      .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_level));

   // ***************************
   // tasks
   // ***************************
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("wrong value at %0t: no ready", $time);
         wrap_up();
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      apb(1'b1, a, {24'h0, wd});
      cmp({31'h0, err_q}, 32'h0, "write error");
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      cmp(rd_q, exp, what);
   endtask

   function automatic logic [7:0] exp_stat(input logic [2:0] m, input int ph);
      logic [7:0] lv;
      lv = (ph == 1) ? 8'hff : 8'h00;
      if (m[2]) return m[0] ? ~lv : lv;
      if (m[1] || !m[0]) return (ph >= 1) ? 8'hff : 8'h00;
      return (ph == 2) ? 8'hff : 8'h00;
   endfunction

   initial begin
      #2000000;
      bad_count++;
      $display("wrong value at %0t: run too long", $time);
      wrap_up();
   end

   // ***************************
   // main sequence
   // ***************************
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      ext_en = 8'hff; ext_val = 8'h00; bad_count = 0; tests_run = 0;
      modes = '{gpio_pkg::GPIO_SENSE_RISE, gpio_pkg::GPIO_SENSE_FALL,
         gpio_pkg::GPIO_SENSE_BOTH, gpio_pkg::GPIO_SENSE_HIGH, gpio_pkg::GPIO_SENSE_LOW,
         gpio_pkg::GPIO_SENSE_BOTH_ALT};
      void'($urandom(32'h6257));
      cyc(20);
      presetn <= 1'b1;
      cyc(2);
      cmp({24'h0, pad_oe_n}, 32'h0000_00ff, "oe after reset");
      rd(`GPIO_OFS_DIR, `GPIO_RST_ZERO, "dir reset");
      rd(`GPIO_OFS_DBPRE, {16'h0, `GPIO_RST_DBPRE}, "prescaler reset");
      $display("test reset done");
      d = 8'($urandom);
      s = 8'($urandom);
      c = 8'($urandom);
      ext_en <= 8'h00;
      wr(`GPIO_OFS_DIR, 8'hff);
      wr(`GPIO_OFS_DOUT, d);
      wr(`GPIO_OFS_SET, s);
      wr(`GPIO_OFS_CLR, c);
      rd(`GPIO_OFS_DOUT, {24'h0, (d | s) & ~c}, "set clear");
      rd(`GPIO_OFS_SET, 32'h0, "set reads zero");
      cmp({24'h0, pad_drive}, {24'h0, (d | s) & ~c}, "pad drive");
      cmp({24'h0, pad_oe_n}, 32'h0, "pad enable");
      cyc(8);
      rd(`GPIO_OFS_DIN, {24'h0, (d | s) & ~c}, "output readback");
      apb(1'b0, 8'h40, 32'h0);
      cmp({31'h0, err_q}, 32'h1, "unmapped error");
      cmp(rd_q, 32'h0, "unmapped data");
      $display("test output done");
      p = 8'($urandom);
      wr(`GPIO_OFS_DIR, 8'h00);
      wr(`GPIO_OFS_PULLEN, 8'hff);
      wr(`GPIO_OFS_PULLUP, p);
      cyc(8);
      rd(`GPIO_OFS_DIN, {24'h0, p}, "pulled level");
      cmp({24'h0, pad_pull_up}, {24'h0, p}, "pull select");
      cmp({24'h0, pad_pull_en}, 32'h0000_00ff, "pull enable");
      $display("test pull done");
      ext_en <= 8'hff;
      wr(`GPIO_OFS_PULLEN, 8'h00);
      for (int m = 0; m < 6; m++) begin
         md = modes[m];
         mk = 8'($urandom);
         wr(`GPIO_OFS_LEVEL, {8{md[2]}});
         wr(`GPIO_OFS_BOTH, {8{md[1]}});
         wr(`GPIO_OFS_POL, {8{md[0]}});
         wr(`GPIO_OFS_INTMASK, mk);
         wr(`GPIO_OFS_INTEN, 8'hff);
         cyc(8);
         wr(`GPIO_OFS_INTSTAT, 8'hff);
         for (int ph = 0; ph < 3; ph++) begin
            ext_val <= (ph == 1) ? 8'hff : 8'h00;
            cyc(8);
            e = exp_stat(md, ph);
            rd(`GPIO_OFS_INTSTAT, {24'h0, e}, "sense status");
            rd(`GPIO_OFS_INTMSTAT, {24'h0, e & mk}, "masked status");
            cmp({31'h0, irq}, {31'h0, |(e & mk)}, "irq level");
         end
         wr(`GPIO_OFS_INTSTAT, 8'hff);
         cyc(2);
         rd(`GPIO_OFS_INTSTAT, {24'h0, md[2] ? exp_stat(md, 2) : 8'h00}, "after clear");
      end
      $display("test interrupt done");
      wr(`GPIO_OFS_LEVEL, 8'h00);
      wr(`GPIO_OFS_BOTH, 8'h00);
      wr(`GPIO_OFS_POL, 8'h00);
      wr(`GPIO_OFS_DBPRE, 8'h01);
      wr(`GPIO_OFS_DBEN, 8'hff);
      wr(`GPIO_OFS_INTSTAT, 8'hff);
      ext_val <= 8'hff;
      cyc(2);
      ext_val <= 8'h00;
      cyc(12);
      rd(`GPIO_OFS_DIN, 32'h0, "glitch data");
      rd(`GPIO_OFS_INTSTAT, 32'h0, "glitch status");
      ext_val <= 8'hff;
      cyc(20);
      rd(`GPIO_OFS_DIN, 32'h0000_00ff, "steady data");
      rd(`GPIO_OFS_INTSTAT, 32'h0000_00ff, "steady status");
      $display("test debounce done");
      wrap_up();
   end
endmodule
